// ===== ssp_top.sv
// signal strength pwm: smoothing filter, registers and pwm generator
//
// Behaviour
// - fixed pwm period of 39.3846 us
// - duty from smoothed value and thresholds
// - above upper threshold: 100% duty
// - below lower threshold: 0% duty
// - accumulate error, add modulo, keep remainder when positive, else the clamped error
// - filter updates once per hop sample
// - smoothing zero bypasses the filter
// - larger smoothing allows larger steps per hop, so responds faster
// - smoothing defaults 0x40, keep below 0x80
// - pin and range from stored configuration
// - samples are unsigned, weak 0x00 strong 0xFF
`timescale 1ns/1ps
`default_nettype none
module ssp_top
    import ssp_pkg::*;
#(
    parameter int PERIOD_CYC = ssp_pkg::SSP_PERIOD_CYC
) (
    // clock and reset
    input  wire logic                              ref_clk_i,
    input  wire logic                              rstn_i,
    // register port
    input  wire ssp_pkg::ssp_bus_t                 bus_i,
    output logic      [7:0]                        rdata_o,
    // per-hop strength sample
    input  wire logic                              sample_valid_i,
    input  wire logic [7:0]                        sample_i,
    // pwm outputs, one per selectable pin
    output logic      [ssp_pkg::SSP_PIN_COUNT-1:0] pwm_o
);
    import ssp_pkg::*;

    logic [7:0]  upper;
    logic [7:0]  lower;
    logic [7:0]  smooth;
    logic [7:0]  control;
    logic [7:0]  average;
    logic signed [10:0] accum;
    logic signed [10:0] next_accum;
    logic signed [10:0] sat_accum;
    logic signed [10:0] rem;
    logic signed [10:0] next_avg_wide;
    logic [7:0]  next_average;
    logic [11:0] duty_new;
    logic [11:0] duty;
    logic [11:0] count;
    logic        pwm_level;

    // ========================================================
    // register writes; thresholds and control steer the pwm
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            upper   <= SSP_RST_UPPER;
            lower   <= SSP_RST_LOWER;
            smooth  <= SSP_RST_SMOOTH;
            control <= SSP_RST_CONTROL;
        end else if (bus_i.wr) begin
            // all settings but the pwm period live in registers, not fixed logic
            case (bus_i.addr)
                SSP_OFF_UPPER:   upper   <= bus_i.wdata;
                SSP_OFF_LOWER:   lower   <= bus_i.wdata;
                SSP_OFF_SMOOTH:  smooth  <= bus_i.wdata;
                SSP_OFF_CONTROL: control <= bus_i.wdata;
                default: ;
            endcase
        end
    end

    // ========================================================
    // read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= 8'h00;
        end else if (bus_i.rd) begin
            case (bus_i.addr)
                SSP_OFF_UPPER:   rdata_o <= upper;
                SSP_OFF_LOWER:   rdata_o <= lower;
                SSP_OFF_SMOOTH:  rdata_o <= smooth;
                SSP_OFF_CONTROL: rdata_o <= control;
                SSP_OFF_AVERAGE: rdata_o <= average;
                SSP_OFF_DUTY:    rdata_o <= duty[11:4];
                default:         rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // ========================================================
    // smoothing filter arithmetic; samples are unsigned bytes
    // the modulo term is the step: each update moves the average by
    // less than the divisor, so big jumps are spread over several hops
    always_comb begin
        next_accum    = accum + 11'(sample_i) - 11'(average);
        rem           = (smooth == 8'h00) ? 11'sd0 : next_accum % $signed(11'(smooth));
        next_avg_wide = 11'(average) + rem;
        if (smooth == 8'h00) begin
            next_average = sample_i;
        end else if (next_avg_wide < 0) begin
            next_average = 8'h00;
        end else if (next_avg_wide > 11'sd255) begin
            next_average = 8'hFF;
        end else begin
            next_average = next_avg_wide[7:0];
        end
    end

    // ========================================================
    // stored error is clamped; a long run of one-sided steps with no
    // positive remainder would otherwise wrap the 11-bit term and flip sign
    always_comb begin
        if (next_accum > 11'sd767) begin
            sat_accum = 11'sd767;
        end else if (next_accum < -11'sd767) begin
            sat_accum = -11'sd767;
        end else begin
            sat_accum = next_accum;
        end
    end

    // ========================================================
    // one filter step per hop measurement
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            accum   <= 11'sd0;
            average <= 8'h00;
        end else if (sample_valid_i) begin
            average <= next_average;
            // positive remainder becomes the new accumulator
            if (smooth == 8'h00) begin
                accum <= 11'sd0;
            end else if (rem > 0) begin
                accum <= rem;
            end else begin
                accum <= sat_accum;
            end
        end
    end

    // ========================================================
    // threshold scaling
    ssp_duty_calc #(
        .PERIOD     (PERIOD_CYC)
    ) u_duty (
        .strength_i (average),
        .upper_i    (upper),
        .lower_i    (lower),
        .duty_o     (duty_new)
    );

    // ========================================================
    // free-running period counter, fixed length
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count <= 12'h000;
        end else if (count == 12'(PERIOD_CYC - 1)) begin
            count <= 12'h000;
        end else begin
            count <= count + 12'h001;
        end
    end

    // ========================================================
    // duty latched only at wrap, avoiding runt pulses
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            duty <= 12'h000;
        end else if (count == 12'(PERIOD_CYC - 1)) begin
            duty <= duty_new;
        end
    end

    // ========================================================
    // compare and steer onto the selected pins
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pwm_level <= 1'b0;
        end else begin
            pwm_level <= (count < duty);
        end
    end

    assign pwm_o = pwm_level ? control[SSP_PIN_COUNT-1:0] : '0;

endmodule
`default_nettype wire

// ===== ssp_pkg.sv
// shared constants and types for the signal strength pwm block
package ssp_pkg;
    // ========================================================
    // register map (byte offsets on the plain register port)
    localparam logic [7:0] SSP_OFF_UPPER    = 8'h65;
    localparam logic [7:0] SSP_OFF_LOWER    = 8'h66;
    localparam logic [7:0] SSP_OFF_SMOOTH   = 8'h67;
    localparam logic [7:0] SSP_OFF_CONTROL  = 8'h68;
    localparam logic [7:0] SSP_OFF_AVERAGE  = 8'h69;
    localparam logic [7:0] SSP_OFF_DUTY     = 8'h6A;

    // ========================================================
    // reset values
    localparam logic [7:0] SSP_RST_UPPER    = 8'hFF;
    localparam logic [7:0] SSP_RST_LOWER    = 8'h00;
    localparam logic [7:0] SSP_RST_SMOOTH   = 8'h40;
    localparam logic [7:0] SSP_RST_CONTROL  = 8'h00;

    // ========================================================
    // control byte fields: low six bits pick output pins
    localparam int SSP_PIN_COUNT            = 6;

    // ========================================================
    // timing: pwm period as printed, then in 100 mhz cycles (rounded down)
    localparam real SSP_PERIOD_NS           = 39384.6;
    localparam real SSP_CLK_NS              = 10.0;
    localparam int  SSP_PERIOD_CYC          = int'($floor(SSP_PERIOD_NS / SSP_CLK_NS));

    // ========================================================
    // register read and write carrier
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ssp_bus_t;
endpackage

// ===== ssp_duty_calc.sv
// combinational threshold scaler: strength byte to pwm compare value
`timescale 1ns/1ps
`default_nettype none
module ssp_duty_calc #(
    parameter int PERIOD = 3938
) (
    // inputs
    input  wire logic [7:0]  strength_i,
    input  wire logic [7:0]  upper_i,
    input  wire logic [7:0]  lower_i,
    // result
    output logic      [11:0] duty_o
);
    logic [7:0]  span;
    logic [7:0]  offs;
    logic [19:0] prod;

    // ========================================================
    // linear map between thresholds, clamped at both ends
    always_comb begin
        span = upper_i - lower_i;
        offs = strength_i - lower_i;
        prod = 20'(offs) * 20'(PERIOD);
        if (strength_i > upper_i) begin
            duty_o = 12'(PERIOD);
        end else if (strength_i < lower_i || span == 8'h00) begin
            duty_o = 12'h000;
        end else begin
            duty_o = 12'(prod / 20'(span));
        end
    end
endmodule
`default_nettype wire

// ===== ssp_top_asserts.sv
// checker of the signal strength pwm ports
`timescale 1ns/1ps
`default_nettype none
module ssp_top_chk
    import ssp_pkg::*;
#(
    parameter int PERIOD_CYC = 20
) (
    // observed ports
    input wire logic                     ref_clk_i,
    input wire logic                     rstn_i,
    input wire ssp_pkg::ssp_bus_t        bus_i,
    input wire logic [7:0]               rdata_o,
    input wire logic                     sample_valid_i,
    input wire logic [7:0]               sample_i,
    input wire logic [SSP_PIN_COUNT-1:0] pwm_o
);
    logic [7:0] sm;
    logic [7:0] ctl;
    logic       seen;
    int         gap;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    // config shadows; gap counts cycles since the last pin 0 rise
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sm   <= 8'h40;
            ctl  <= 8'h00;
            seen <= 1'b0;
            gap  <= 0;
        end else begin
            if (bus_i.wr && bus_i.addr == SSP_OFF_SMOOTH) sm <= bus_i.wdata;
            if (bus_i.wr && bus_i.addr == SSP_OFF_CONTROL) ctl <= bus_i.wdata;
            seen <= seen | $rose(pwm_o[0]);
            gap  <= $rose(pwm_o[0]) ? 1 : gap + 1;
        end
    end
    sequence s_rd(logic [7:0] a); bus_i.rd && bus_i.addr == a; endsequence
    sequence s_wr_lo; bus_i.wr && bus_i.addr == SSP_OFF_LOWER; endsequence
    sequence s_byp; sample_valid_i && sm == 8'h00; endsequence
    property p_rd_idle; !$past(bus_i.rd) |-> rdata_o == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("idle read data");
    property p_lo_back;
        s_wr_lo ##2 s_rd(SSP_OFF_LOWER) |=> rdata_o == $past(bus_i.wdata, 3);
    endproperty
    a_lo_back: assert property (p_lo_back) else $error("lower readback");
    property p_sm_read; s_rd(SSP_OFF_SMOOTH) |=> rdata_o == $past(sm); endproperty
    a_sm_read: assert property (p_sm_read) else $error("smoothing readback");
    property p_unmap;
        bus_i.rd && (bus_i.addr < SSP_OFF_UPPER || bus_i.addr > SSP_OFF_DUTY)
            |=> rdata_o == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_gate; (pwm_o & ~ctl[SSP_PIN_COUNT-1:0]) == '0; endproperty
    a_gate: assert property (p_gate) else $error("disabled pin driven");
    property p_same;
        ctl[0] |-> pwm_o == ({SSP_PIN_COUNT{pwm_o[0]}} & ctl[SSP_PIN_COUNT-1:0]);
    endproperty
    a_same: assert property (p_same) else $error("pins differ");
    property p_period; $rose(pwm_o[0]) && seen |-> gap % PERIOD_CYC == 0; endproperty
    a_period: assert property (p_period) else $error("rise off period");
    property p_bypass;
        s_byp ##2 s_rd(SSP_OFF_AVERAGE) |=> rdata_o == $past(sample_i, 3);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass average");
endmodule
bind ssp_top ssp_top_chk #(.PERIOD_CYC(PERIOD_CYC)) i_ssp_top_chk (.ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i), .bus_i(bus_i), .rdata_o(rdata_o), .sample_valid_i(sample_valid_i),
    .sample_i(sample_i), .pwm_o(pwm_o));
`default_nettype wire

// ===== ssp_pwm_meter.sv
// partner model: observer of one pwm pin counting high cycles
`timescale 1ns/1ps
`default_nettype none
module ssp_pwm_meter (
    // clock, clear and observed pin
    input  wire logic ref_clk_i,
    input  wire logic clr_i,
    input  wire logic pin_i,
    // high cycles since the clear
    output var  int   ones_o
);
    // over one whole period the count is the duty, whatever the phase
    always_ff @(posedge ref_clk_i) begin
        ones_o <= clr_i ? 0 : ones_o + int'(pin_i);
    end
endmodule
`default_nettype wire

// ===== signal_strength_pwm_tb_top.sv
// self-checking testbench of the signal strength pwm block
`timescale 1ns/1ps
`default_nettype none
module signal_strength_pwm_tb_top;
    import ssp_pkg::*;
    localparam int P = 20;
    logic                     ref_clk_i = 1'b0;
    logic                     rstn_i    = 1'b0;
    ssp_bus_t                 bus       = '0;
    logic                     sv        = 1'b0;
    logic [7:0]               smp_v     = 8'h00;
    logic                     clr       = 1'b0;
    logic [7:0]               rdata;
    logic [7:0]               rv;
    logic [SSP_PIN_COUNT-1:0] pwm;
    int ones;
    int err_count  = 0;
    int num_checks = 0;
    int cyc        = 0;
    int avg        = 255;
    int acc        = 0;
    // rows: bypassed sample, expected high cycles per period
    int rows [7][2] = '{'{8'hFF, 20}, '{8'h10, 0}, '{8'h70, 0}, '{8'hD4, 20},
                        '{8'hA2, 10}, '{8'h75, 1}, '{8'hD3, 19}};
    logic [7:0] rst [4] = '{8'hFF, 8'h00, 8'h40, 8'h00};
    always #5 ref_clk_i = ~ref_clk_i;
    ssp_top #(.PERIOD_CYC(P)) i_ssp_top (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .bus_i(bus),
        .rdata_o(rdata), .sample_valid_i(sv), .sample_i(smp_v), .pwm_o(pwm));
    ssp_pwm_meter i_ssp_pwm_meter (.ref_clk_i(ref_clk_i), .clr_i(clr), .pin_i(pwm[0]),
        .ones_o(ones));
    // ========================================
    // bus, sample and check tasks
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        bus <= {1'b1, 1'b0, a, d};
        @(posedge ref_clk_i);
        bus <= '0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk_i);
        bus <= {1'b0, 1'b1, a, 8'h00};
        @(posedge ref_clk_i);
        bus <= '0;
        #1 rv = rdata;
    endtask
    // sample line shows the inverse once not valid
    task automatic smp(input logic [7:0] v);
        @(posedge ref_clk_i);
        sv <= 1'b1;
        smp_v <= v;
        @(posedge ref_clk_i);
        sv <= 1'b0;
        smp_v <= ~v;
    endtask
    // wait for the new duty to start, then count one whole period
    task automatic meas(input int e);
        repeat (2 * P) @(posedge ref_clk_i);
        clr <= 1'b1;
        @(posedge ref_clk_i);
        clr <= 1'b0;
        repeat (P) @(posedge ref_clk_i);
        #1 chk("duty", e, ones);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // hang guard, far above the roughly 550 cycles needed
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            summarize();
        end
    end
    initial begin
        repeat (4) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(SSP_OFF_UPPER + 8'(i));
            chk("reset value", rst[i], rv);
        end
        rd(8'h00);
        chk("unmapped", 0, rv);
        wr(SSP_OFF_UPPER, 8'hD4); // 40 dBm
        wr(SSP_OFF_LOWER, 8'h70); // 90 dBm
        rd(SSP_OFF_LOWER);
        chk("lower", 8'h70, rv);
        wr(SSP_OFF_SMOOTH, 8'h00);
        wr(SSP_OFF_CONTROL, 8'h3F);
        $display("reset and config test done");
        for (int i = 0; i < 7; i++) begin
            smp(8'(rows[i][0]));
            rd(SSP_OFF_AVERAGE);
            chk("average", rows[i][0], rv);
            meas(rows[i][1]);
            rd(SSP_OFF_DUTY);
            chk("duty reg", rows[i][1] >> 4, rv);
            $display("row %0d done", i);
        end
        wr(SSP_OFF_CONTROL, 8'h21);
        smp(8'hFF);
        repeat (2 * P) @(posedge ref_clk_i);
        #1 chk("pins", 8'h21, pwm);
        $display("pin select test done");
        wr(SSP_OFF_SMOOTH, 8'h07);
        for (int i = 0; i < 3; i++) begin
            smp(8'h90);
            acc = acc + 144 - avg;
            avg = avg + acc % 7;
            acc = (acc % 7 > 0) ? acc % 7 : acc;
            rd(SSP_OFF_AVERAGE);
            chk("filtered", avg, rv);
        end
        $display("filter test done");
        summarize();
    end
endmodule
`default_nettype wire
